// ===== testbench/aal_flag_model.sv
// Flag register model standing beside the datapath slice
`timescale 1ns/10ps
module aal_flag_model
(
    input wire logic clk,
    input wire logic rst_b,
    input wire logic flags_wr,
    input wire logic [5:0] flags_out,
    input wire logic load,
    input wire logic [5:0] load_flags,
    output logic [5:0] flags_in
);
    logic [5:0] flag_reg;

    // Written flags land one edge after the completion pulse
    always_ff @(posedge clk)
    begin
        if (!rst_b)
            flag_reg <= 6'h00;
        else if (load)
            flag_reg <= load_flags;
        else if (flags_wr)
            flag_reg <= flags_out;
    end

    assign flags_in = flag_reg;
endmodule

// ===== testbench/tb_add_and_logic_alu_ops.sv
// Self-checking bench for the add, add-with-carry and AND slice
`timescale 1ns/10ps
`include "aal_consts.svh"
module tb_add_and_logic_alu_ops;
    typedef struct {
        logic ill;
        logic [7:0] addr;
        logic [7:0] data;
        logic [5:0] flg;
    } aal_note_type;

    logic clk, rst_b, start, busy, done, illegal, wr_en, flags_wr, load;
    logic dst_work, src_work;
    logic [7:0] opcode, dst_addr, src_addr, dst_val, src_val;
    logic [7:0] wr_addr, wr_data;
    logic [5:0] flags_in, flags_out, load_flags, flg_m;
    logic [3:0] dst_wnum, src_wnum;
    logic [3:0] ops [3] = '{`AAL_HI_ADD, `AAL_HI_ADC, `AAL_HI_AND};
    logic [7:0] bad [5] = '{8'h20, 8'h01, 8'h58, 8'h18, 8'hf6};
    aal_note_type notes [$];
    aal_note_type seen;
    int num_errors = 0;
    int comparisons = 0;

    aal_core dut_u (.clk(clk), .rst_b(rst_b), .start(start),
        .opcode(opcode), .dst_addr(dst_addr), .src_addr(src_addr),
        .dst_val(dst_val), .src_val(src_val), .flags_in(flags_in),
        .busy(busy), .done(done), .illegal(illegal), .wr_en(wr_en),
        .wr_addr(wr_addr), .wr_data(wr_data), .flags_wr(flags_wr),
        .flags_out(flags_out), .dst_work(dst_work), .dst_wnum(dst_wnum),
        .src_work(src_work), .src_wnum(src_wnum));

    aal_flag_model part_u (.clk(clk), .rst_b(rst_b), .flags_wr(flags_wr),
        .flags_out(flags_out), .load(load), .load_flags(load_flags),
        .flags_in(flags_in));

    initial
    begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end

    task automatic chk(input string nm, input logic [7:0] e,
        input logic [7:0] g);
        comparisons++;
        if (g !== e)
        begin
            num_errors++;
            $display("[FAIL] %s expected %h seen %h", nm, e, g);
        end
    endtask

    task automatic tally_and_finish;
        $display("Comparisons %0d, mismatches %0d", comparisons, num_errors);
        if (num_errors == 0 && comparisons > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask

    task automatic setf(input logic [5:0] f);
        @(negedge clk);
        load = 1'b1;
        load_flags = f;
        flg_m = f;
        @(negedge clk);
        load = 1'b0;
    endtask

    // One instruction; poke keeps start high one more cycle while busy
    task automatic run(input logic [3:0] hi, input logic [3:0] lo,
        input logic [7:0] da, input logic [7:0] sa, input logic [7:0] dv,
        input logic [7:0] sv, input bit poke);
        aal_note_type n;
        logic [8:0] sum;
        logic [4:0] hs;
        logic cin, ok, sh;
        int k;
        ok = (hi == `AAL_HI_ADD || hi == `AAL_HI_ADC || hi == `AAL_HI_AND)
            && lo >= 4'h2 && lo <= 4'h7;
        cin = (hi == `AAL_HI_ADC) ? flg_m[5] : 1'b0;
        sum = {1'b0, dv} + {1'b0, sv} + {8'h00, cin};
        hs = {1'b0, dv[3:0]} + {1'b0, sv[3:0]} + {4'h0, cin};
        sh = lo <= 4'h3;
        n.ill = !ok;
        n.addr = da;
        n.data = (hi == `AAL_HI_AND) ? (dv & sv) : sum[7:0];
        if (hi == `AAL_HI_AND)
            n.flg = {flg_m[5], n.data == 8'h00, n.data[7], 1'b0, flg_m[1:0]};
        else
            n.flg = {sum[8], sum[7:0] == 8'h00, sum[7],
                dv[7] == sv[7] && sum[7] != dv[7], 1'b0, hs[4]};
        notes.push_back(n);
        if (ok)
            flg_m = n.flg;
        @(negedge clk);
        start = 1'b1;
        opcode = {hi, lo};
        dst_addr = da;
        src_addr = sa;
        dst_val = dv;
        src_val = sv;
        @(negedge clk);
        start = poke;
        dst_addr = ~da;
        src_addr = ~sa;
        dst_val = ~dv;
        src_val = ~sv;
        if (!ok)
        begin
            chk("busy", 8'h00, {7'h00, busy});
            return;
        end
        chk("dst_work", {7'h00, sh || da[7:4] == 4'he}, {7'h00, dst_work});
        chk("dst_wnum", {4'h0, da[3:0]}, {4'h0, dst_wnum});
        chk("src_work", {7'h00, sh || (lo <= 4'h5 && sa[7:4] == 4'he)},
            {7'h00, src_work});
        chk("src_wnum", {4'h0, sa[3:0]}, {4'h0, src_wnum});
        k = 0;
        if (poke)
        begin
            @(negedge clk);
            start = 1'b0;
            k = 1;
        end
        while (done !== 1'b1 && k < 20)
        begin
            @(negedge clk);
            k++;
        end
        if (done !== 1'b1)
        begin
            num_errors++;
            tally_and_finish();
        end
        chk("cycles", sh ? 8'h06 : 8'h0a, 8'(k));
        chk("busy_end", 8'h00, {7'h00, busy});
        @(negedge clk);
    endtask

    // Scoreboard: each completion or refusal takes the oldest note
    always @(negedge clk)
    begin
        if (done === 1'b1 || illegal === 1'b1)
        begin
            if (notes.size() == 0)
                chk("note", 8'h00, 8'h01);
            else
            begin
                seen = notes.pop_front();
                chk("illegal", {7'h00, seen.ill}, {7'h00, illegal});
                if (!seen.ill)
                begin
                    chk("wr_en", 8'h01, {7'h00, wr_en});
                    chk("wr_addr", seen.addr, wr_addr);
                    chk("wr_data", seen.data, wr_data);
                    chk("flags_wr", 8'h01, {7'h00, flags_wr});
                    chk("flags", {2'h0, seen.flg}, {2'h0, flags_out});
                end
            end
        end
    end

    initial
    begin
        rst_b = 1'b0;
        start = 1'b0;
        load = 1'b0;
        load_flags = 6'h00;
        opcode = 8'h00;
        dst_addr = 8'h00;
        src_addr = 8'h00;
        dst_val = 8'h00;
        src_val = 8'h00;
        flg_m = 6'h00;
        void'($urandom(4));
        repeat (20) @(negedge clk);
        chk("reset", 8'h00, {busy, done, wr_en, flags_wr, illegal, 3'h0});
        rst_b = 1'b1;
        run(`AAL_HI_ADD, 4'h4, 8'h10, 8'h20, 8'h44, 8'h11, 1'b0);
        setf(6'h20);
        run(`AAL_HI_ADC, 4'h5, 8'h10, 8'hea, 8'h16, 8'h10, 1'b0);
        setf(6'h23);
        run(`AAL_HI_AND, 4'h6, 8'he3, 8'h00, 8'hc3, 8'h7b, 1'b1);
        run(`AAL_HI_ADD, 4'h2, 8'he1, 8'he2, 8'hff, 8'h01, 1'b0);
        run(`AAL_HI_ADC, 4'h3, 8'he4, 8'he5, 8'h7f, 8'h00, 1'b0);
        run(`AAL_HI_AND, 4'h7, 8'h30, 8'h00, 8'h80, 8'hff, 1'b0);
        for (int o = 0; o < 3; o++)
            for (int m = 2; m < 8; m++)
                run(ops[o], 4'(m), 8'($urandom), 8'($urandom),
                    8'($urandom), 8'($urandom), 1'b0);
        foreach (bad[i])
            run(bad[i][7:4], bad[i][3:0], 8'h01, 8'h02, 8'h03, 8'h04, 1'b0);
        repeat (80)
        begin
            if ($urandom_range(3) == 0)
                setf(6'($urandom));
            run(ops[$urandom_range(2)], 4'($urandom_range(7, 2)),
                8'($urandom), 8'($urandom), 8'($urandom), 8'($urandom),
                1'($urandom));
        end
        chk("notes_left", 8'h00, 8'(notes.size()));
        tally_and_finish();
    end
endmodule

// ===== verilog/aal_arith.sv
// Result and flag generation for add, add-with-carry and AND
`timescale 1ns/10ps
`include "aal_consts.svh"
module aal_arith
(
    input wire aal_pkg::aal_op_type op,
    input wire logic [7:0] dst_val,
    input wire logic [7:0] src_val,
    input wire logic [5:0] flags_in,
    output logic [7:0] result,
    output logic [5:0] flags
);

    logic cin;
    logic [8:0] sum;
    logic [4:0] low_sum;

    always_comb
    begin
        cin = (op == aal_pkg::AAL_OP_ADC) ? flags_in[`AAL_FLAG_C] : 1'b0;
        sum = {1'b0, dst_val} + {1'b0, src_val} + {8'h00, cin};
        low_sum = {1'b0, dst_val[3:0]} + {1'b0, src_val[3:0]} + {4'h0, cin};
        flags = flags_in;
        if (op == aal_pkg::AAL_OP_AND)
        begin
            result = dst_val & src_val;
            flags[`AAL_FLAG_Z] = (result == 8'h00);
            flags[`AAL_FLAG_S] = result[7];
            flags[`AAL_FLAG_V] = 1'b0;
        end
        else
        begin
            result = sum[7:0];
            flags[`AAL_FLAG_C] = sum[8];
            flags[`AAL_FLAG_Z] = (result == 8'h00);
            flags[`AAL_FLAG_S] = result[7];
            flags[`AAL_FLAG_V] = (dst_val[7] == src_val[7])
                && (result[7] != dst_val[7]);
            flags[`AAL_FLAG_D] = 1'b0;
            flags[`AAL_FLAG_H] = low_sum[4];
        end
    end

endmodule

// ===== verilog/aal_consts.svh
// Constants for the add, add-with-carry and AND datapath slice
// Behaviour
// - Add-with-carry writes dst plus src plus carry to dst; src untouched.
// - Additions set carry on carry out of bit 7, else clear it.
// - All three instructions set zero when the 8-bit result is zero.
// - Additions set sign when result bit 7 is one, else clear it.
// - Additions set overflow when like-signed operands give opposite sign.
// - Additions set half-carry on carry out of bit 3, else clear it.
// - Register byte with upper nibble E names a working register; its low 4 bits give the number.
// - AND writes bitwise dst AND src to dst; src untouched.
// - AND clears overflow and keeps carry, half-carry and decimal-adjust.
// - AND copies result bit 7 into the sign flag.
// - Low opcode nibble 2 to 7 selects the addressing pair.
`ifndef AAL_CONSTS_SVH
`define AAL_CONSTS_SVH

// Upper opcode nibbles
`define AAL_HI_ADD 4'h0
`define AAL_HI_ADC 4'h1
`define AAL_HI_AND 4'h5

// Lower opcode nibble: addressing pair dst,src
`define AAL_MODE_WORK_WORK 4'h2
`define AAL_MODE_WORK_INDIRECT_WORKING_REG 4'h3
`define AAL_MODE_REG_REG 4'h4
`define AAL_MODE_REG_INDIRECT_REGISTER 4'h5
`define AAL_MODE_REG_IMMEDIATE 4'h6
`define AAL_MODE_INDIRECT_REGISTER_IMMEDIATE 4'h7

// Upper nibble marking a working-register operand byte
`define AAL_WORK_PREFIX 4'he

// Execution lengths in clock cycles
`define AAL_CYC_SHORT 4'h6
`define AAL_CYC_LONG 4'ha

// Flag positions in the six-bit flag vector
`define AAL_FLAG_C 5
`define AAL_FLAG_Z 4
`define AAL_FLAG_S 3
`define AAL_FLAG_V 2
`define AAL_FLAG_D 1
`define AAL_FLAG_H 0

`define AAL_FLAGS_RESET 6'h00

`endif

// ===== verilog/aal_core.sv
// Sequenced add, add-with-carry and AND datapath slice
`timescale 1ns/10ps
`include "aal_consts.svh"
module aal_core
(
    input wire logic clk,
    input wire logic rst_b,
    input wire logic start,
    input wire logic [7:0] opcode,
    input wire logic [7:0] dst_addr,
    input wire logic [7:0] src_addr,
    input wire logic [7:0] dst_val,
    input wire logic [7:0] src_val,
    input wire logic [5:0] flags_in,
    output logic busy,
    output logic done,
    output logic illegal,
    output logic wr_en,
    output logic [7:0] wr_addr,
    output logic [7:0] wr_data,
    output logic flags_wr,
    output logic [5:0] flags_out,
    output logic dst_work,
    output logic [3:0] dst_wnum,
    output logic src_work,
    output logic [3:0] src_wnum
);

    aal_pkg::aal_regs_type regs_reg;
    aal_pkg::aal_regs_type regs_next;

    logic dec_valid;
    aal_pkg::aal_op_type dec_op;
    logic [3:0] dec_cycles;
    logic dec_dst_work;
    logic [3:0] dec_dst_wnum;
    logic dec_src_work;
    logic [3:0] dec_src_wnum;
    logic [7:0] alu_res;
    logic [5:0] alu_flags;

    aal_opdec u_opdec
    (
        .opcode(opcode),
        .dst_addr(dst_addr),
        .src_addr(src_addr),
        .valid(dec_valid),
        .op(dec_op),
        .cycles(dec_cycles),
        .dst_work(dec_dst_work),
        .dst_wnum(dec_dst_wnum),
        .src_work(dec_src_work),
        .src_wnum(dec_src_wnum)
    );

    // Operates on operands captured at start
    aal_arith u_arith
    (
        .op(regs_reg.op),
        .dst_val(regs_reg.dst_val),
        .src_val(regs_reg.src_val),
        .flags_in(regs_reg.flags_in),
        .result(alu_res),
        .flags(alu_flags)
    );

    always_comb
    begin
        regs_next = regs_reg;
        regs_next.done = 1'b0;
        regs_next.wr_en = 1'b0;
        regs_next.flags_wr = 1'b0;
        regs_next.illegal = 1'b0;
        case (regs_reg.state)
            aal_pkg::AAL_IDLE:
            begin
                if (start)
                begin
                    if (dec_valid)
                    begin
                        regs_next.state = aal_pkg::AAL_EXEC;
                        regs_next.busy = 1'b1;
                        regs_next.op = dec_op;
                        regs_next.cnt = dec_cycles;
                        regs_next.dst_val = dst_val;
                        regs_next.src_val = src_val;
                        regs_next.flags_in = flags_in;
                        regs_next.dst_addr = dst_addr;
                        regs_next.dst_work = dec_dst_work;
                        regs_next.dst_wnum = dec_dst_wnum;
                        regs_next.src_work = dec_src_work;
                        regs_next.src_wnum = dec_src_wnum;
                    end
                    else
                    begin
                        regs_next.illegal = 1'b1;
                    end
                end
            end
            aal_pkg::AAL_EXEC:
            begin
                if (regs_reg.cnt == 4'h1)
                begin
                    regs_next.state = aal_pkg::AAL_IDLE;
                    regs_next.busy = 1'b0;
                    regs_next.done = 1'b1;
                    // Only the destination is written back
                    regs_next.wr_en = 1'b1;
                    regs_next.wr_addr = regs_reg.dst_addr;
                    regs_next.wr_data = alu_res;
                    regs_next.flags_wr = 1'b1;
                    regs_next.flags_out = alu_flags;
                end
                else
                begin
                    regs_next.cnt = regs_reg.cnt - 4'h1;
                end
            end
            default:
            begin
                regs_next.state = aal_pkg::AAL_IDLE;
                regs_next.busy = 1'b0;
            end
        endcase
    end

    always_ff @(posedge clk)
    begin
        if (!rst_b)
        begin
            regs_reg <= '0;
            regs_reg.state <= aal_pkg::AAL_IDLE;
            regs_reg.flags_out <= `AAL_FLAGS_RESET;
        end
        else
        begin
            regs_reg <= regs_next;
        end
    end

    assign busy = regs_reg.busy;
    assign done = regs_reg.done;
    assign illegal = regs_reg.illegal;
    assign wr_en = regs_reg.wr_en;
    assign wr_addr = regs_reg.wr_addr;
    assign wr_data = regs_reg.wr_data;
    assign flags_wr = regs_reg.flags_wr;
    assign flags_out = regs_reg.flags_out;
    assign dst_work = regs_reg.dst_work;
    assign dst_wnum = regs_reg.dst_wnum;
    assign src_work = regs_reg.src_work;
    assign src_wnum = regs_reg.src_wnum;

    // Reference values for checking, from captured operands
    logic [7:0] chk_a;
    logic [7:0] chk_b;
    logic chk_c;
    logic [8:0] chk_sum_c;
    logic [8:0] chk_sum;
    logic [4:0] chk_low;
    logic chk_add;
    logic chk_start;

    always_comb
    begin
        chk_a = regs_reg.dst_val;
        chk_b = regs_reg.src_val;
        chk_c = regs_reg.flags_in[`AAL_FLAG_C];
        chk_sum_c = {1'b0, chk_a} + {1'b0, chk_b} + {8'h00, chk_c};
        chk_sum = {1'b0, chk_a} + {1'b0, chk_b};
        chk_low = {1'b0, chk_a[3:0]} + {1'b0, chk_b[3:0]}
            + {4'h0, regs_reg.op == aal_pkg::AAL_OP_ADC && chk_c};
        chk_add = regs_reg.op != aal_pkg::AAL_OP_AND;
        chk_start = start && regs_reg.state == aal_pkg::AAL_IDLE
            && dec_valid;
    end

    property p_adc_sum;
        @(posedge clk) disable iff (!rst_b)
        done && regs_reg.op == aal_pkg::AAL_OP_ADC
            |-> wr_data == chk_sum_c[7:0] && wr_addr == regs_reg.dst_addr;
    endproperty
    a_adc_sum: assert property (p_adc_sum) else $error("adc sum wrong");

    property p_carry;
        @(posedge clk) disable iff (!rst_b)
        done && regs_reg.op == aal_pkg::AAL_OP_ADC
            |-> flags_out[`AAL_FLAG_C] == chk_sum_c[8];
    endproperty
    a_carry: assert property (p_carry) else $error("carry flag wrong");

    property p_zero;
        @(posedge clk) disable iff (!rst_b)
        done |-> flags_out[`AAL_FLAG_Z] == (wr_data == 8'h00);
    endproperty
    a_zero: assert property (p_zero) else $error("zero flag wrong");

    property p_sign_add;
        @(posedge clk) disable iff (!rst_b)
        done && chk_add |-> flags_out[`AAL_FLAG_S] == wr_data[7];
    endproperty
    a_sign_add: assert property (p_sign_add) else $error("sign wrong");

    property p_ovf;
        @(posedge clk) disable iff (!rst_b)
        done && chk_add |-> flags_out[`AAL_FLAG_V]
            == (chk_a[7] == chk_b[7] && wr_data[7] != chk_a[7]);
    endproperty
    a_ovf: assert property (p_ovf) else $error("overflow wrong");

    property p_dec_clr;
        @(posedge clk) disable iff (!rst_b)
        done && chk_add |-> !flags_out[`AAL_FLAG_D] && flags_wr;
    endproperty
    a_dec_clr: assert property (p_dec_clr) else $error("d flag set");

    property p_half;
        @(posedge clk) disable iff (!rst_b)
        done && chk_add |-> flags_out[`AAL_FLAG_H] == chk_low[4];
    endproperty
    a_half: assert property (p_half) else $error("half carry wrong");

    property p_work;
        @(posedge clk) disable iff (!rst_b)
        chk_start && opcode[3:0] == `AAL_MODE_REG_REG
            && dst_addr[7:4] == `AAL_WORK_PREFIX
            |=> dst_work && dst_wnum == $past(dst_addr[3:0]);
    endproperty
    a_work: assert property (p_work) else $error("work reg decode");

    property p_and;
        @(posedge clk) disable iff (!rst_b)
        done && !chk_add |-> wr_data == (chk_a & chk_b);
    endproperty
    a_and: assert property (p_and) else $error("and result wrong");

    property p_and_flags;
        @(posedge clk) disable iff (!rst_b)
        done && !chk_add |-> !flags_out[`AAL_FLAG_V]
            && flags_out[`AAL_FLAG_C] == regs_reg.flags_in[`AAL_FLAG_C]
            && flags_out[`AAL_FLAG_H] == regs_reg.flags_in[`AAL_FLAG_H]
            && flags_out[`AAL_FLAG_D] == regs_reg.flags_in[`AAL_FLAG_D];
    endproperty
    a_and_flags: assert property (p_and_flags) else $error("and flags");

    property p_and_sign;
        @(posedge clk) disable iff (!rst_b)
        done && !chk_add |-> flags_out[`AAL_FLAG_S] == wr_data[7];
    endproperty
    a_and_sign: assert property (p_and_sign) else $error("and sign");

    property p_add_sum;
        @(posedge clk) disable iff (!rst_b)
        done && regs_reg.op == aal_pkg::AAL_OP_ADD
            |-> wr_data == chk_sum[7:0]
            && flags_out[`AAL_FLAG_C] == chk_sum[8];
    endproperty
    a_add_sum: assert property (p_add_sum) else $error("add sum wrong");

    property p_short;
        @(posedge clk) disable iff (!rst_b)
        chk_start && dec_cycles == `AAL_CYC_SHORT
            |=> (busy && !done)[*6] ##1 done;
    endproperty
    a_short: assert property (p_short) else $error("short form length");

    property p_long;
        @(posedge clk) disable iff (!rst_b)
        chk_start && dec_cycles == `AAL_CYC_LONG |-> ##10 !done ##1 done;
    endproperty
    a_long: assert property (p_long) else $error("long form length");

    property p_decode;
        @(posedge clk) disable iff (!rst_b)
        start && regs_reg.state == aal_pkg::AAL_IDLE
            && (opcode[3:0] < `AAL_MODE_WORK_WORK
            || opcode[3:0] > `AAL_MODE_INDIRECT_REGISTER_IMMEDIATE)
            |=> illegal && !busy;
    endproperty
    a_decode: assert property (p_decode) else $error("bad mode taken");

endmodule

// ===== verilog/aal_opdec.sv
// Opcode and operand address decode
`timescale 1ns/10ps
`include "aal_consts.svh"
module aal_opdec
(
    input wire logic [7:0] opcode,
    input wire logic [7:0] dst_addr,
    input wire logic [7:0] src_addr,
    output logic valid,
    output aal_pkg::aal_op_type op,
    output logic [3:0] cycles,
    output logic dst_work,
    output logic [3:0] dst_wnum,
    output logic src_work,
    output logic [3:0] src_wnum
);

    logic [3:0] hi;
    logic [3:0] lo;
    logic hi_ok;
    logic dst_pre;
    logic src_pre;

    always_comb
    begin
        hi = opcode[7:4];
        lo = opcode[3:0];
        hi_ok = 1'b1;
        op = aal_pkg::AAL_OP_ADD;
        case (hi)
            `AAL_HI_ADD: op = aal_pkg::AAL_OP_ADD;
            `AAL_HI_ADC: op = aal_pkg::AAL_OP_ADC;
            `AAL_HI_AND: op = aal_pkg::AAL_OP_AND;
            default: hi_ok = 1'b0;
        endcase
        dst_pre = (dst_addr[7:4] == `AAL_WORK_PREFIX);
        src_pre = (src_addr[7:4] == `AAL_WORK_PREFIX);
        dst_wnum = dst_addr[3:0];
        src_wnum = src_addr[3:0];
        valid = hi_ok;
        cycles = `AAL_CYC_LONG;
        dst_work = 1'b0;
        src_work = 1'b0;
        case (lo)
            `AAL_MODE_WORK_WORK, `AAL_MODE_WORK_INDIRECT_WORKING_REG:
            begin
                cycles = `AAL_CYC_SHORT;
                dst_work = 1'b1;
                src_work = 1'b1;
            end
            `AAL_MODE_REG_REG, `AAL_MODE_REG_INDIRECT_REGISTER:
            begin
                dst_work = dst_pre;
                src_work = src_pre;
            end
            `AAL_MODE_REG_IMMEDIATE,
            `AAL_MODE_INDIRECT_REGISTER_IMMEDIATE:
            begin
                dst_work = dst_pre;
            end
            default: valid = 1'b0;
        endcase
    end

endmodule

// ===== verilog/aal_pkg.sv
// Types shared by the datapath slice
package aal_pkg;

    typedef enum logic [1:0] {AAL_OP_ADD, AAL_OP_ADC, AAL_OP_AND} aal_op_type;

    typedef enum logic {AAL_IDLE, AAL_EXEC} aal_state_type;

    typedef struct packed {
        aal_state_type state;
        aal_op_type op;
        logic [3:0] cnt;
        logic [7:0] dst_val;
        logic [7:0] src_val;
        logic [5:0] flags_in;
        logic [7:0] dst_addr;
        logic busy;
        logic done;
        logic wr_en;
        logic [7:0] wr_addr;
        logic [7:0] wr_data;
        logic [5:0] flags_out;
        logic flags_wr;
        logic illegal;
        logic dst_work;
        logic [3:0] dst_wnum;
        logic src_work;
        logic [3:0] src_wnum;
    } aal_regs_type;

endpackage
